// ===== rtl/mpa_pkg.sv
// package for the motor protection supervisor: widths, defaults, timing, carriers
// assumes currents and speed are unsigned fixed point, 1.0 of rated = 1024 (q10)
package mpa_pkg;
	localparam int CUR_W = 16;
	localparam int SPD_W = 16;
	localparam int FAULT_W = 3;
	localparam int CLK_HZ = 250_000_000;
	// one pu in q10 scaling
	localparam logic [CUR_W-1:0] PU_ONE = 16'h0400;
	// default overload points as q10 factors of rated current
	localparam logic [CUR_W-1:0] OL_FULL_FACTOR = 16'h0433; // 1.05
	localparam logic [CUR_W-1:0] OL_HALF_FACTOR = 16'h039a; // 0.90
	localparam logic [CUR_W-1:0] OL_LOW_FACTOR = 16'h029a;  // 0.65
	localparam logic [CUR_W-1:0] OL_PM_FACTOR = 16'h0433;   // 1.05
	// speed curve points in q10 of rated speed
	localparam logic [SPD_W-1:0] SPD_FULL = 16'h0400; // 100 %
	localparam logic [SPD_W-1:0] SPD_HALF = 16'h0200; // 50 %
	localparam logic [SPD_W-1:0] SPD_LOW = 16'h0033;  // 5 %
	localparam logic [SPD_W-1:0] SPD_UNB_MIN = 16'h001f; // 3 %
	localparam logic [CUR_W-1:0] UNB_FACTOR = 16'h0080;  // 0.125
	// timing in seconds and derived cycle counts
	localparam int UNB_TIME_S = 2;
	localparam int CONSEC_TIME_S = 30;
	localparam longint UNB_CYCLES = longint'(UNB_TIME_S) * CLK_HZ;
	localparam longint CONSEC_CYCLES = longint'(CONSEC_TIME_S) * CLK_HZ;
	localparam longint SEC_CYCLES = longint'(CLK_HZ);
	localparam logic [7:0] AR_MIN_DELAY = 8'h02; // delay at or below: no auto reset
	localparam logic [1:0] REPEAT_LIMIT = 2'h3;
	localparam logic [3:0] THERM_CLASS_MAX = 4'h8;
	localparam logic [2:0] CTRL_PM_SENSORLESS = 3'h6;
	localparam logic [2:0] CTRL_PM_ENCODER = 3'h7;
	localparam logic VENT_SELF = 1'b0;

	// fault codes
	typedef enum logic [FAULT_W-1:0] {
		FLT_NONE = 3'b000,
		FLT_OVERLOAD = 3'b001,
		FLT_UNBALANCE = 3'b010,
		FLT_OVERTEMP = 3'b011,
		FLT_ENCODER = 3'b100,
		FLT_OFFSET = 3'b101,
		FLT_OTHER = 3'b110
	} mpa_fault_type;

	typedef enum logic [1:0] {
		OLM_OFF = 2'b00,
		OLM_FAULT_ALARM = 2'b01,
		OLM_FAULT = 2'b10,
		OLM_ALARM = 2'b11
	} mpa_olmode_type;

	// measured phase currents
	typedef struct packed {
		logic [CUR_W-1:0] iu;
		logic [CUR_W-1:0] iv;
		logic [CUR_W-1:0] iw;
	} mpa_phase_type;

	// overload curve points
	typedef struct packed {
		logic [CUR_W-1:0] full;
		logic [CUR_W-1:0] half;
		logic [CUR_W-1:0] low;
	} mpa_curve_type;
endpackage : mpa_pkg

// ===== rtl/mpa_ol_interp.sv
// speed dependent overload threshold: linear interpolation between three points
// assumes curve points and speed settle for a cycle before being used
`timescale 1ns/100ps
`default_nettype none
module mpa_ol_interp
	import mpa_pkg::*;
(
	input wire logic core_clk,                // control clock
	input wire logic sys_rst,                 // sync reset
	input wire mpa_curve_type curve,          // three curve points
	input wire logic [SPD_W-1:0] speed,       // speed, q10 of rated
	output logic [CUR_W-1:0] threshold        // registered threshold
);
	typedef struct packed {
		logic [CUR_W-1:0] thr;
	} mpa_interp_state_type;

	mpa_interp_state_type st_q, st_d;
	logic signed [CUR_W+1:0] dy;
	logic [SPD_W-1:0] dx;
	logic [SPD_W-1:0] span;
	logic [CUR_W-1:0] base;
	logic signed [CUR_W+SPD_W+2:0] prod;

	assign threshold = st_q.thr;

	always_comb begin
		st_d = st_q;
		dx = '0;
		span = 16'h0001;
		base = curve.low;
		dy = '0;
		if (speed >= SPD_FULL) begin
			base = curve.full;
		end else if (speed >= SPD_HALF) begin
			base = curve.half;
			dx = speed - SPD_HALF;
			span = SPD_FULL - SPD_HALF;
			dy = $signed({2'b00, curve.full}) - $signed({2'b00, curve.half});
		end else if (speed > SPD_LOW) begin
			dx = speed - SPD_LOW;
			span = SPD_HALF - SPD_LOW;
			dy = $signed({2'b00, curve.half}) - $signed({2'b00, curve.low});
		end
		prod = (dy * $signed({3'b000, dx})) / $signed({3'b000, span});
		st_d.thr = CUR_W'($signed({3'b000, base}) + prod);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : mpa_ol_interp
`default_nettype wire

// ===== rtl/mpa_supervisor.sv
// motor protection supervisor: overload trip, auto reset with lockout,
// voltage compensation select, unbalanced current detection
// assumes all inputs come from logic on core_clk except temp_normal (a pin)
//
// Summary of operation
// - motor overloaded while current exceeds the speed dependent threshold.
// - bigger excess over threshold gives faster overload trip.
// - threshold curve from points at 100, 50 and 5 percent speed.
// - default points are 1.05, 0.9 and 0.65 times rated current.
// - points recomputed when rated current, ventilation or application change in start-up.
// - thermal class code 0..8 gives class 5..45; higher class trips later.
// - faults clear after auto reset delay, except encoder wiring and offset faults.
// - temperature faults auto reset only once temperature is normal again.
// - three consecutive repeats disable auto reset; drive stays disabled.
// - repeat is consecutive only within 30 seconds after the auto reset.
// - auto reset delay of 2 or less suppresses auto reset.
// - voltage compensation on limits motor voltage to rated in scalar control only; off applies none unless energy saving is enabled.
// - compensation always applies while energy saving is enabled.
// - unbalance detection enable, 0 off, 1 on, off after reset.
// - unbalance fault when all conditions hold over 2 seconds.
// - any fault blocks firing pulses so the motor coasts.
// - thermal image kept in nonvolatile storage and resumed after restart.
// - overload mode 0 off, 1 fault and alarm, 2 fault, 3 alarm.
`timescale 1ns/100ps
`default_nettype none
module mpa_supervisor
	import mpa_pkg::*;
#(
	parameter longint UNB_CYC = UNB_CYCLES,       // unbalance persistence
	parameter longint CONSEC_CYC = CONSEC_CYCLES, // consecutive window
	parameter longint SEC_CYC = SEC_CYCLES,       // one second of clocks
	parameter int OL_ACC_LIMIT = 32'h0100_0000    // class 5 trip integral
)(
	input wire logic core_clk,                          // control clock
	input wire logic sys_rst,                           // sync reset
	input wire mpa_phase_type phase_cur,                // phase currents q10
	input wire logic [CUR_W-1:0] motor_current,         // motor current q10
	input wire logic [SPD_W-1:0] speed_ref,             // speed ref q10
	input wire logic drive_enable,                      // drive enabled
	input wire logic [CUR_W-1:0] motor_rated_current,   // rated current q10
	input wire logic motor_ventilation_type,            // 0 self ventilated
	input wire logic [2:0] control_mode_select,         // control mode
	input wire logic [1:0] drive_application_setting,   // application
	input wire logic startup_active,                    // guided start-up
	input wire mpa_curve_type curve_wr_data,            // manual points
	input wire logic curve_wr,                          // manual point write
	input wire logic [3:0] thermal_class_select,        // 0..8
	input wire logic [7:0] auto_reset_delay,            // seconds
	input wire logic voltage_comp_enable,               // 1 on
	input wire logic energy_saving_enable,              // energy saving
	input wire logic scalar_control,                    // v/f mode
	input wire logic unbalance_detect_enable,           // 1 on
	input wire logic [1:0] overload_protection_mode,    // mode code
	input wire mpa_fault_type ext_fault,                // other faults
	input wire logic ext_fault_valid,                   // pulse
	input wire logic temp_normal,                       // pin, temp in range
	input wire logic [31:0] thermal_image_restore,      // saved image
	input wire logic restore_valid,                     // pulse at restart
	output logic pulse_block,                           // fire pulses off
	output mpa_fault_type fault_code,                   // active fault
	output logic motor_overload_fault,                  // overload trip
	output logic overload_alarm,                        // overload warning
	output logic unbalanced_current_fault,              // unbalance trip
	output logic auto_reset_locked,                     // lockout
	output logic voltage_comp_active,                   // limit to rated
	output logic [31:0] thermal_image,                  // image to store
	output mpa_curve_type overload_levels               // curve points
);
	typedef struct packed {
		logic tn1, tn2;
		mpa_curve_type curve;
		logic [CUR_W-1:0] rated_prev;
		logic vent_prev;
		logic [1:0] app_prev;
		logic [31:0] acc;
		mpa_fault_type fault;
		mpa_fault_type last_fault;
		logic [31:0] unb_cnt;
		logic [39:0] ar_cnt;
		logic [39:0] win_cnt;
		logic win_open;
		logic [1:0] repeats;
		logic locked;
		logic ol_trip, ol_alarm, unb_trip, vcomp, blk;
	} mpa_sup_state_type;

	mpa_sup_state_type st_q, st_d;
	logic [CUR_W-1:0] thr;
	logic [CUR_W-1:0] excess;
	logic [CUR_W-1:0] d_uv, d_uw, d_vw, unb_lim;
	logic unb_cond, recompute, ol_raise, new_fault;
	mpa_fault_type raise_code;
	logic [31:0] acc_limit;

	function automatic logic [CUR_W-1:0] absdiff(input logic [CUR_W-1:0] a, input logic [CUR_W-1:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction : absdiff

	function automatic logic [CUR_W-1:0] scale_rated(input logic [CUR_W-1:0] r, input logic [CUR_W-1:0] f);
		logic [2*CUR_W-1:0] p;
		p = r * f;
		scale_rated = p[CUR_W+9:10];
	endfunction : scale_rated

	mpa_ol_interp u_interp (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.curve(st_q.curve),
		.speed(speed_ref),
		.threshold(thr)
	);

	assign pulse_block = st_q.blk;
	assign fault_code = st_q.fault;
	assign motor_overload_fault = st_q.ol_trip;
	assign overload_alarm = st_q.ol_alarm;
	assign unbalanced_current_fault = st_q.unb_trip;
	assign auto_reset_locked = st_q.locked;
	assign voltage_comp_active = st_q.vcomp;
	assign thermal_image = st_q.acc;
	assign overload_levels = st_q.curve;

	// derived combinational terms
	always_comb begin
		excess = (motor_current > thr) ? motor_current - thr : '0;
		d_uv = absdiff(phase_cur.iu, phase_cur.iv);
		d_uw = absdiff(phase_cur.iu, phase_cur.iw);
		d_vw = absdiff(phase_cur.iv, phase_cur.iw);
		unb_lim = scale_rated(motor_rated_current, UNB_FACTOR);
		unb_cond = unbalance_detect_enable && drive_enable && (speed_ref > SPD_UNB_MIN)
			&& ((d_uv > unb_lim) || (d_uw > unb_lim) || (d_vw > unb_lim));
		recompute = startup_active && ((motor_rated_current != st_q.rated_prev)
			|| (motor_ventilation_type != st_q.vent_prev) || (drive_application_setting != st_q.app_prev));
		acc_limit = 32'(OL_ACC_LIMIT * (int'(thermal_class_select > THERM_CLASS_MAX ? THERM_CLASS_MAX
			: thermal_class_select) + 1));
	end

	always_comb begin
		st_d = st_q;
		// pin synchroniser
		st_d.tn1 = temp_normal;
		st_d.tn2 = st_q.tn1;
		st_d.rated_prev = motor_rated_current;
		st_d.vent_prev = motor_ventilation_type;
		st_d.app_prev = drive_application_setting;
		if (recompute) begin
			if ((control_mode_select == CTRL_PM_SENSORLESS || control_mode_select == CTRL_PM_ENCODER)
				&& motor_ventilation_type == VENT_SELF) begin
				st_d.curve.full = scale_rated(motor_rated_current, OL_PM_FACTOR);
				st_d.curve.half = scale_rated(motor_rated_current, OL_PM_FACTOR);
				st_d.curve.low = scale_rated(motor_rated_current, OL_PM_FACTOR);
			end else if (motor_ventilation_type == VENT_SELF) begin
				st_d.curve.full = scale_rated(motor_rated_current, OL_FULL_FACTOR);
				st_d.curve.half = scale_rated(motor_rated_current, OL_HALF_FACTOR);
				st_d.curve.low = scale_rated(motor_rated_current, OL_LOW_FACTOR);
			end else begin
				st_d.curve.full = scale_rated(motor_rated_current, OL_FULL_FACTOR);
				st_d.curve.half = st_d.curve.full;
				st_d.curve.low = st_d.curve.full;
			end
		end else if (curve_wr) begin
			st_d.curve = curve_wr_data;
		end
		if (restore_valid) begin
			st_d.acc = thermal_image_restore;
		end else if (excess != '0) begin
			st_d.acc = (st_q.acc > ~32'(excess)) ? '1 : st_q.acc + 32'(excess);
		end else if (st_q.acc != '0) begin
			st_d.acc = st_q.acc - 32'h1; // cooling
		end
		ol_raise = (st_q.acc >= acc_limit) && (overload_protection_mode == OLM_FAULT_ALARM
			|| overload_protection_mode == OLM_FAULT);
		st_d.ol_alarm = (st_q.acc >= (acc_limit >> 1)) && (overload_protection_mode == OLM_FAULT_ALARM
			|| overload_protection_mode == OLM_ALARM);
		if (!unb_cond) begin
			st_d.unb_cnt = '0;
		end else if (st_q.unb_cnt <= 32'(UNB_CYC)) begin
			st_d.unb_cnt = st_q.unb_cnt + 32'h1;
		end
		st_d.vcomp = (scalar_control && voltage_comp_enable) || energy_saving_enable;
		// fault raising, first fault holds
		new_fault = 1'b0;
		raise_code = FLT_NONE;
		if (ol_raise) begin
			new_fault = 1'b1;
			raise_code = FLT_OVERLOAD;
		end else if (st_q.unb_cnt > 32'(UNB_CYC)) begin
			new_fault = 1'b1;
			raise_code = FLT_UNBALANCE;
		end else if (ext_fault_valid && ext_fault != FLT_NONE) begin
			new_fault = 1'b1;
			raise_code = ext_fault;
		end
		// consecutive window runs after each auto reset
		if (st_q.win_open) begin
			if (st_q.win_cnt >= 40'(CONSEC_CYC)) begin
				st_d.win_open = 1'b0;
				st_d.repeats = '0;
			end else begin
				st_d.win_cnt = st_q.win_cnt + 40'h1;
			end
		end
		if (st_q.fault == FLT_NONE) begin
			if (new_fault) begin
				st_d.fault = raise_code;
				st_d.last_fault = raise_code;
				st_d.ol_trip = raise_code == FLT_OVERLOAD;
				st_d.unb_trip = raise_code == FLT_UNBALANCE;
				st_d.ar_cnt = '0;
				st_d.win_open = 1'b0;
				if (st_q.win_open && raise_code == st_q.last_fault) begin
					st_d.repeats = st_q.repeats + 2'h1;
					if (st_q.repeats == REPEAT_LIMIT - 2'h1) begin
						st_d.locked = 1'b1;
					end
				end else begin
					st_d.repeats = '0;
				end
			end
		end else begin
			st_d.ar_cnt = st_q.ar_cnt + 40'h1;
			// auto reset after delay, excluded faults stay
			if (!st_q.locked && auto_reset_delay > AR_MIN_DELAY
				&& st_q.fault != FLT_ENCODER && st_q.fault != FLT_OFFSET
				&& st_q.ar_cnt >= 40'(SEC_CYC) * 40'(auto_reset_delay)
				&& (st_q.fault != FLT_OVERTEMP || st_q.tn2)) begin
				st_d.fault = FLT_NONE;
				st_d.ol_trip = 1'b0;
				st_d.unb_trip = 1'b0;
				st_d.unb_cnt = '0;
				st_d.win_open = 1'b1;
				st_d.win_cnt = '0;
			end
		end
		// pulse block registered with the fault it follows
		st_d.blk = st_d.fault != FLT_NONE;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
			// default points at 1.0 pu rating
			st_q.curve.full <= OL_FULL_FACTOR;
			st_q.curve.half <= OL_HALF_FACTOR;
			st_q.curve.low <= OL_LOW_FACTOR;
			// no recompute pending at 1.0 pu rating
			st_q.rated_prev <= PU_ONE;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : mpa_supervisor
`default_nettype wire

// ===== verif/mpa_supervisor_props.sv
// checker for the motor protection supervisor, bound to its top ports
// assumes one clock core_clk and the synchronous reset sys_rst
`timescale 1ns/100ps
`default_nettype none
module mpa_supervisor_chk
	import mpa_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic sys_rst, // reset
	input wire mpa_phase_type phase_cur, // currents
	input wire logic [SPD_W-1:0] speed_ref, // speed
	input wire logic drive_enable, // enabled
	input wire logic [CUR_W-1:0] motor_rated_current, // rated
	input wire logic unbalance_detect_enable, // unb on
	input wire logic voltage_comp_enable, // comp on
	input wire logic energy_saving_enable, // saving
	input wire logic scalar_control, // v/f
	input wire logic [1:0] overload_protection_mode, // mode
	input wire mpa_fault_type ext_fault, // code
	input wire logic ext_fault_valid, // strobe
	input wire logic temp_normal, // temp ok
	input wire logic [7:0] auto_reset_delay, // seconds
	input wire logic pulse_block, // fault
	input wire mpa_fault_type fault_code, // active code
	input wire logic motor_overload_fault, // trip
	input wire logic overload_alarm, // warning
	input wire logic unbalanced_current_fault, // trip
	input wire logic auto_reset_locked, // lockout
	input wire logic voltage_comp_active // comp
);
	// phase difference against one eighth of rated
	function automatic logic [CUR_W-1:0] dif(input logic [CUR_W-1:0] a, input logic [CUR_W-1:0] b);
		return (a > b) ? a - b : b - a;
	endfunction : dif
	wire logic [CUR_W-1:0] lim;
	wire logic unb_cond;
	assign lim = motor_rated_current >> 3;
	assign unb_cond = unbalance_detect_enable && drive_enable && (speed_ref > SPD_UNB_MIN) &&
		((dif(phase_cur.iu, phase_cur.iv) > lim) || (dif(phase_cur.iu, phase_cur.iw) > lim) ||
		(dif(phase_cur.iv, phase_cur.iw) > lim));
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_hot;
		!temp_normal [*3];
	endsequence
	sequence s_unb_off;
		!unbalance_detect_enable [*4];
	endsequence
	property p_vcomp;
		!$past(sys_rst) |-> voltage_comp_active == $past((voltage_comp_enable && scalar_control) || energy_saving_enable);
	endproperty
	property p_block;
		motor_overload_fault || unbalanced_current_fault || auto_reset_locked |-> pulse_block;
	endproperty
	property p_answer;
		ext_fault_valid && !pulse_block && ext_fault != FLT_NONE |=> pulse_block && fault_code != FLT_NONE;
	endproperty
	property p_olmode_off;
		(overload_protection_mode == OLM_OFF) [*2] |-> !$rose(motor_overload_fault) && !$rose(overload_alarm);
	endproperty
	property p_unb_off;
		s_unb_off |-> !$rose(unbalanced_current_fault);
	endproperty
	property p_unb_held;
		$rose(unbalanced_current_fault) |-> $past(unb_cond, 2) && $past(unb_cond, 12);
	endproperty
	property p_lock;
		auto_reset_locked |=> auto_reset_locked && pulse_block;
	endproperty
	property p_temp;
		s_hot ##0 fault_code == FLT_OVERTEMP |=> fault_code == FLT_OVERTEMP;
	endproperty
	property p_enc;
		fault_code inside {FLT_ENCODER, FLT_OFFSET} |=> fault_code == $past(fault_code);
	endproperty
	property p_small_delay;
		$stable(auto_reset_delay) && auto_reset_delay <= AR_MIN_DELAY && pulse_block |=> pulse_block;
	endproperty
	a_vcomp: assert property (p_vcomp) else $error("compensation output wrong");
	a_block: assert property (p_block) else $error("trip without pulse block");
	a_answer: assert property (p_answer) else $error("fault not taken");
	a_olmode_off: assert property (p_olmode_off) else $error("overload event while off");
	a_unb_off: assert property (p_unb_off) else $error("unbalance trip while off");
	a_unb_held: assert property (p_unb_held) else $error("unbalance trip too early");
	a_lock: assert property (p_lock) else $error("lockout released");
	a_temp: assert property (p_temp) else $error("hot fault cleared");
	a_enc: assert property (p_enc) else $error("wiring or offset fault cleared");
	a_small_delay: assert property (p_small_delay) else $error("cleared with short delay");
endmodule : mpa_supervisor_chk
bind mpa_supervisor mpa_supervisor_chk u_mpa_supervisor_chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.phase_cur(phase_cur), .speed_ref(speed_ref), .drive_enable(drive_enable),
	.motor_rated_current(motor_rated_current), .unbalance_detect_enable(unbalance_detect_enable),
	.voltage_comp_enable(voltage_comp_enable), .energy_saving_enable(energy_saving_enable),
	.scalar_control(scalar_control), .overload_protection_mode(overload_protection_mode),
	.ext_fault(ext_fault), .ext_fault_valid(ext_fault_valid), .temp_normal(temp_normal),
	.auto_reset_delay(auto_reset_delay), .pulse_block(pulse_block), .fault_code(fault_code),
	.motor_overload_fault(motor_overload_fault), .overload_alarm(overload_alarm),
	.unbalanced_current_fault(unbalanced_current_fault), .auto_reset_locked(auto_reset_locked),
	.voltage_comp_active(voltage_comp_active));
`default_nettype wire

// ===== verif/test_motor_protection_autoreset.sv
// self-checking bench for the motor protection supervisor
// assumes short counts: one second is 10 clocks, window 100, unbalance 20
`timescale 1ns/100ps
`default_nettype none
module test_motor_protection_autoreset
	import mpa_pkg::*;
;
	logic core_clk = 0, sys_rst = 1, drive_enable = 0, vent = 0, startup = 0, cwr = 0, vce = 0, es = 0;
	logic scalar = 0, ude = 0, efv = 0, temp_ok = 1;
	logic [15:0] cur = 0, spd = 0, rated = 16'h0400;
	logic [3:0] cls = 0;
	logic [7:0] delay = 0;
	logic [1:0] mode = 0;
	mpa_phase_type ph = '0;
	mpa_curve_type cwd = '0;
	mpa_fault_type efc = FLT_NONE;
	logic [2:0] cms = 3'h0;
	logic [1:0] app = 2'h0;
	logic rv = 1'b0;
	logic [31:0] img = 32'h0000_0000, timg;
	logic pb, olf, ola, unf, lock, vca;
	mpa_fault_type fc;
	mpa_curve_type lv;
	int miscompares = 0, n_tests = 0, n, a, b, c;
	bit al;
	mpa_supervisor #(.UNB_CYC(20), .CONSEC_CYC(100), .SEC_CYC(10), .OL_ACC_LIMIT(1000)) u_mpa_supervisor (
		.core_clk(core_clk), .sys_rst(sys_rst), .phase_cur(ph), .motor_current(cur), .speed_ref(spd),
		.drive_enable(drive_enable), .motor_rated_current(rated), .motor_ventilation_type(vent),
		.control_mode_select(cms), .drive_application_setting(app), .startup_active(startup),
		.curve_wr_data(cwd), .curve_wr(cwr), .thermal_class_select(cls), .auto_reset_delay(delay),
		.voltage_comp_enable(vce), .energy_saving_enable(es), .scalar_control(scalar),
		.unbalance_detect_enable(ude), .overload_protection_mode(mode), .ext_fault(efc),
		.ext_fault_valid(efv), .temp_normal(temp_ok), .thermal_image_restore(img),
		.restore_valid(rv), .pulse_block(pb), .fault_code(fc), .motor_overload_fault(olf),
		.overload_alarm(ola), .unbalanced_current_fault(unf), .auto_reset_locked(lock),
		.voltage_comp_active(vca), .thermal_image(timg), .overload_levels(lv));
	// free running clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// reset for three cycles, loads back to quiet values
	task automatic do_reset;
		@(posedge core_clk);
		sys_rst <= 1;
		cur <= 0;
		ph <= '0;
		ude <= 0;
		drive_enable <= 0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		@(posedge core_clk);
	endtask : do_reset
	// waits for: 0 fault cleared, 1 overload trip, 2 unbalance trip
	task automatic wait_for(input int sel, input int lim, output int k);
		for (k = 0; k < lim; k++) begin
			@(posedge core_clk);
			#1;
			if ((sel == 0 && !pb) || (sel == 1 && olf) || (sel == 2 && unf))
				break;
		end
	endtask : wait_for
	task automatic inject(input mpa_fault_type f);
		@(posedge core_clk);
		efc <= f;
		efv <= 1;
		@(posedge core_clk);
		efv <= 0;
		#1;
		chk({pb, fc}, {1'b1, f});
	endtask : inject
	task automatic t_curve;
		do_reset();
		chk(lv, {16'h0433, 16'h039a, 16'h029a});
		cwd <= {16'h0400, 16'h0300, 16'h0200};
		cwr <= 1;
		@(posedge core_clk);
		cwr <= 0;
		startup <= 1;
		repeat (3) @(posedge core_clk);
		chk(lv, {16'h0400, 16'h0300, 16'h0200});
		rated <= 16'h0800;
		repeat (4) @(posedge core_clk);
		chk(lv, {16'h0866, 16'h0734, 16'h0534});
		vent <= 1;
		repeat (4) @(posedge core_clk);
		chk(lv, {3{16'h0866}});
		vent <= 0;
		cms <= 3'h6;
		app <= 2'h1;
		repeat (4) @(posedge core_clk);
		chk(lv, {3{16'h0866}});
		cms <= 3'h0;
		app <= 2'h0;
		repeat (4) @(posedge core_clk);
		chk(lv, {16'h0866, 16'h0734, 16'h0534});
		rated <= 16'h0400;
		startup <= 0;
	endtask : t_curve
	task automatic t_vcomp;
		for (int k = 0; k < 8; k++) begin
			@(posedge core_clk);
			{vce, es, scalar} <= k[2:0];
			@(posedge core_clk);
			#1;
			chk(vca, (k[2] & k[0]) | k[1]);
		end
	endtask : t_vcomp
	// same fault inside the window: fourth occurrence stays
	task automatic t_lock(input int gap);
		do_reset();
		delay <= 3;
		for (int i = 0; i < 4; i++) begin
			inject(FLT_OTHER);
			wait_for(0, 60, n);
			chk(n < 60, gap > 0 || i < 3);
			repeat (gap) @(posedge core_clk);
		end
		chk(lock, gap == 0);
	endtask : t_lock
	task automatic t_noreset;
		mpa_fault_type f[3] = '{FLT_OTHER, FLT_ENCODER, FLT_OFFSET};
		for (int i = 0; i < 3; i++) begin
			do_reset();
			delay <= (i == 0) ? 8'h02 : 8'h05;
			inject(f[i]);
			wait_for(0, 100, n);
			chk(n, 100);
		end
		do_reset();
		delay <= 3;
		temp_ok <= 0;
		inject(FLT_OVERTEMP);
		wait_for(0, 100, n);
		chk(n, 100);
		@(posedge core_clk);
		temp_ok <= 1;
		wait_for(0, 60, n);
		chk(n < 60, 1);
	endtask : t_noreset
	task automatic ol_run(input logic [15:0] i, input logic [15:0] s, input logic [3:0] c, input logic [1:0] m,
		input int lim, output int k);
		do_reset();
		cur <= i;
		spd <= s;
		cls <= c;
		mode <= m;
		al = 0;
		for (k = 0; k < lim; k++) begin
			@(posedge core_clk);
			#1;
			al |= ola;
			if (olf)
				break;
		end
	endtask : ol_run
	task automatic t_overload;
		ol_run(16'h0440, 16'h0400, 0, 2, 20000, a);
		ol_run(16'h0800, 16'h0400, 0, 2, 20000, b);
		ol_run(16'h0440, 16'h0400, 8, 2, 20000, c);
		chk(a < 20000 && b < a, 1);
		chk(c > a && c < 20000, 1);
		ol_run(16'h0410, 16'h0400, 0, 2, 3000, n);
		chk(n, 3000);
		ol_run(16'h0410, 16'h0300, 0, 2, 3000, n);
		chk(n < 3000, 1);
		for (int m = 0; m < 4; m++) begin
			ol_run(16'h0800, 16'h0400, 0, m, 3000, n);
			chk({n < 3000, al}, {m == 1 || m == 2, m == 1 || m == 3});
		end
	endtask : t_overload
	// saved image is taken back and cooling resumes from it
	task automatic t_restore;
		do_reset();
		mode <= 0;
		img <= 32'h0000_0123;
		rv <= 1;
		@(posedge core_clk);
		rv <= 0;
		#1;
		chk(timg, 32'h0000_0123);
		@(posedge core_clk);
		#1;
		chk(timg, 32'h0000_0122);
	endtask : t_restore
	task automatic unb_run(input logic en, input logic [15:0] s, output int k);
		do_reset();
		ude <= en;
		drive_enable <= 1;
		spd <= s;
		ph <= {16'h0400, 16'h0300, 16'h0400};
		wait_for(2, 60, k);
	endtask : unb_run
	task automatic t_unb;
		unb_run(1, 16'h0100, n);
		chk(n >= 20 && n <= 24, 1);
		unb_run(0, 16'h0100, n);
		chk(n, 60);
		unb_run(1, 16'h001f, n);
		chk(n, 60);
	endtask : t_unb
	// watchdog against a hang
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
	// main sequence
	initial begin
		t_curve();
		t_vcomp();
		t_lock(0);
		t_lock(120);
		t_noreset();
		t_overload();
		t_restore();
		t_unb();
		give_verdict();
	end
endmodule : test_motor_protection_autoreset
`default_nettype wire
